//--- rtl/flash_rewrite_bus_control.sv
/*
 * Flash rewrite bus control: timing, boundary, protect, mode and flash status registers.
 * Assumes an APB master, pin-level flash status and an external bus unit fed by the outputs.
 */
`timescale 1ns/1ps
`include "frbc_defines.svh"

// Functional notes
// - Timing fields accept optimal encoding values
// - Optimal timing fields read back 5885h
// - Single-chip: primary timing for both areas
// - Expansion: data area uses secondary timing
// - Timing registers share external bus storage
// - Expansion-mode timing write forces separate 16-bit, no wait
// - Rewrite ignores hold; multiplexed spaces blocked
// - Protected writes only while key AAh
// - Ready, lock status, lock read mode bits
// - Final command busy flag while not acceptable
// - Enable bit zero returns normal mode
// - Enable bit one enters rewrite mode
// - Abort event resets control, read array
module flash_rewrite_bus_control #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        memExpansionPin,
  input  wire logic        holdRequestPin,
  input  wire logic        extWaitPin,
  input  wire logic [3:0]  abortEventPins,
  input  wire logic        flashReadyPin,
  input  wire logic        flashFinalBusyPin,
  input  wire logic        flashLockPin,
  output logic      [15:0] progAreaTiming,
  output logic      [15:0] dataAreaTiming,
  output logic             rewriteMode,
  output logic             cpuHeldRewrite,
  output logic      [1:0]  csForcedFormat,
  output logic      [1:0]  csDataBlocked,
  output logic             extWaitAccepted,
  output logic             holdAck,
  output logic             flashReadArray,
  output logic             lockViaDataBus
);
  // Elaboration check on the synchroniser depth.
  initial begin
    if (SYNC_STAGES < 2) begin
      $error("SYNC_STAGES must be at least 2");
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  frbc_reg_if regBus ();  // Register access channel.

  // APB front end.
  frbc_apb_slave u_apb (
    .core_clk (core_clk),
    .rstn     (rstn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .bus      (regBus)
  );

  // All pin inputs cross through the synchroniser before use.
  logic [8:0] pinSync;  // Synchronised pins.
  frbc_sync #(.WIDTH(9), .STAGES(SYNC_STAGES)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .din      ({flashLockPin, flashFinalBusyPin, flashReadyPin, abortEventPins,
                extWaitPin, holdRequestPin}),
    .dout     (pinSync)
  );
  wire holdReq   = pinSync[0];         // Bus hold request.
  wire extWait   = pinSync[1];         // External wait input.
  wire abortEvt  = |pinSync[5:2];      // Any of the four abort sources.
  wire flashRdy  = pinSync[6];         // Flash ready for read.
  wire finalBusy = pinSync[7];         // Flash cannot take the last command yet.
  wire lockPin   = pinSync[8];         // Lock status from the flash.

  // Expansion mode is a level sampled after synchronisation.
  logic memExpansion;       // Registered expansion mode strap.
  logic memExpansionPin_q;  // Synchronised strap pin.
  always_ff @(posedge core_clk) begin
    if (!rstn) memExpansion <= 1'b0;
    else       memExpansion <= memExpansionPin_q;
  end
  frbc_sync #(.WIDTH(1), .STAGES(SYNC_STAGES)) u_strap (
    .core_clk (core_clk),
    .rstn     (rstn),
    .din      (memExpansionPin),
    .dout     (memExpansionPin_q)
  );

  // Stored registers.
  frbc_pkg::frbc_timing_type timing0;  // Timing 0, shared with external bus control 0.
  frbc_pkg::frbc_timing_type timing3;  // Timing 3, shared with external bus control 3.
  logic [7:0] boundA;                  // Chip-select boundary A.
  logic [7:0] boundB;                  // Chip-select boundary B.
  logic [7:0] boundC;                  // Chip-select boundary C.
  logic [7:0] protectRelease;          // Protect release key register.
  logic       rewriteEnable;           // Rewrite mode enable bit.
  logic       modeSelect;              // Rewrite mode select bit.
  logic       lockReadMode;            // Lock read mode bit.
  logic [1:0] busMux;                  // Multiplexed format of spaces 0 and 3.
  frbc_pkg::frbc_mode_type mode;       // Current mode.

  // Address decode: one wire per register.
  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction
  wire selT0 = isAddr(regBus.addr, `FRBC_OFS_TIMING0);
  wire selT3 = isAddr(regBus.addr, `FRBC_OFS_TIMING3);
  wire selBA = isAddr(regBus.addr, `FRBC_OFS_BOUND_A);
  wire selBB = isAddr(regBus.addr, `FRBC_OFS_BOUND_B);
  wire selBC = isAddr(regBus.addr, `FRBC_OFS_BOUND_C);
  wire selFC = isAddr(regBus.addr, `FRBC_OFS_FCTRL0);
  wire selPR = isAddr(regBus.addr, `FRBC_OFS_PROTECT);
  wire selMC = isAddr(regBus.addr, `FRBC_OFS_MODECTL);
  wire selBF = isAddr(regBus.addr, `FRBC_OFS_BUSFMT);
  assign regBus.hit = selT0 | selT3 | selBA | selBB | selBC | selFC | selPR | selMC | selBF;

  // Protected registers take writes only while the key is held.
  wire unlocked = (protectRelease == `FRBC_PROTECT_KEY);
  wire protWr   = regBus.wrEn & unlocked;
  wire timingWr = protWr & (selT0 | selT3);

  // Timing value seen by software: stored fields plus the fixed-one bits.
  function automatic logic [15:0] timRead(input logic [15:0] t);
    return (t & `FRBC_TIM_MASK) | `FRBC_TIM_FIXED;
  endfunction
  wire [15:0] readT0 = timRead(timing0);
  wire [15:0] readT3 = timRead(timing3);

  // Flash control register 0 read view; lock status shows only in status mode.
  wire lockFlag = lockReadMode & lockPin;
  wire [7:0] fctrlRead = {3'b000, finalBusy, flashRdy, lockFlag, lockReadMode, modeSelect};

  // Read multiplexer; unmapped reads return zero.
  assign regBus.rdata = selT0 ? {16'h0000, readT0} :
                        selT3 ? {16'h0000, readT3} :
                        selBA ? {24'h000000, boundA} :
                        selBB ? {24'h000000, boundB} :
                        selBC ? {24'h000000, boundC} :
                        selFC ? {24'h000000, fctrlRead} :
                        selPR ? {24'h000000, protectRelease} :
                        selMC ? {31'h0000_0000, rewriteEnable} :
                        selBF ? {30'h0000_0000, busMux} : 32'h0000_0000;

  // Timing and boundary registers; one storage for timing and bus control.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      timing0 <= `FRBC_TIM_RESET;
      timing3 <= `FRBC_TIM_RESET;
      boundA  <= `FRBC_BYTE_RESET;
      boundB  <= `FRBC_BYTE_RESET;
      boundC  <= `FRBC_BYTE_RESET;
    end else begin
      if (protWr && selT0) timing0 <= regBus.wdata[15:0] & `FRBC_TIM_MASK;
      if (protWr && selT3) timing3 <= regBus.wdata[15:0] & `FRBC_TIM_MASK;
      if (protWr && selBA) boundA <= regBus.wdata[7:0];
      if (protWr && selBB) boundB <= regBus.wdata[7:0];
      if (protWr && selBC) boundC <= regBus.wdata[7:0];
    end
  end

  // Protect key register; free to write at any time.
  always_ff @(posedge core_clk) begin
    if (!rstn) protectRelease <= `FRBC_BYTE_RESET;
    else if (regBus.wrEn && selPR) protectRelease <= regBus.wdata[7:0];
  end

  // Mode enable (protected) and flash control bits; an abort clears the latter.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rewriteEnable <= 1'b0;
      modeSelect    <= 1'b0;
      lockReadMode  <= 1'b0;
    end else begin
      if (protWr && selMC) rewriteEnable <= regBus.wdata[`FRBC_MC_ENABLE];
      if (abortEvt) begin
        modeSelect   <= 1'b0;
        lockReadMode <= 1'b0;
      end else if (regBus.wrEn && selFC) begin
        modeSelect   <= regBus.wdata[`FRBC_FC_MODESEL];
        lockReadMode <= regBus.wdata[`FRBC_FC_LOCKMODE];
      end
    end
  end

  // Bus format: a timing write in expansion mode forces separate format; the force wins over a bus format write.
  wire forceSep = timingWr & memExpansion;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      busMux <= 2'b00;
    end else if (forceSep) begin
      busMux <= 2'b00;
    end else if (protWr && selBF) begin
      busMux <= regBus.wdata[1:0];
    end
  end

  // Mode state follows the enable and select bits.
  frbc_pkg::frbc_mode_type next_mode;
  always_comb begin
    case (mode)
      frbc_pkg::FRBC_NORMAL:       next_mode = rewriteEnable ? frbc_pkg::FRBC_REWRITE
                                                             : frbc_pkg::FRBC_NORMAL;
      frbc_pkg::FRBC_REWRITE,
      frbc_pkg::FRBC_REWRITE_HELD: next_mode = !rewriteEnable ? frbc_pkg::FRBC_NORMAL
                                               : modeSelect ? frbc_pkg::FRBC_REWRITE_HELD
                                               : frbc_pkg::FRBC_REWRITE;
      default:                     next_mode = frbc_pkg::FRBC_NORMAL;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) mode <= frbc_pkg::FRBC_NORMAL;
    else       mode <= next_mode;
  end

  // Registered outputs toward the flash and external bus units.
  wire inRewrite = (mode != frbc_pkg::FRBC_NORMAL);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      progAreaTiming  <= 16'h0000;
      dataAreaTiming  <= 16'h0000;
      rewriteMode     <= 1'b0;
      cpuHeldRewrite  <= 1'b0;
      csForcedFormat  <= 2'b00;
      csDataBlocked   <= 2'b00;
      extWaitAccepted <= 1'b0;
      holdAck         <= 1'b0;
      flashReadArray  <= 1'b0;
      lockViaDataBus  <= 1'b0;
    end else begin
      progAreaTiming  <= readT0;
      dataAreaTiming  <= memExpansion ? readT3 : readT0;
      rewriteMode     <= inRewrite;
      cpuHeldRewrite  <= (mode == frbc_pkg::FRBC_REWRITE_HELD);
      if (forceSep) csForcedFormat <= 2'b11;
      csDataBlocked   <= inRewrite ? busMux : 2'b00;
      extWaitAccepted <= extWait & ~(|csForcedFormat);
      holdAck         <= holdReq & ~inRewrite;
      flashReadArray  <= abortEvt;
      lockViaDataBus  <= ~lockReadMode;
    end
  end

  // Assertions.
  sequence s_blocked_timing_write;
    regBus.wrEn && selT0 && !unlocked;
  endsequence
  a_protect_blocks_write: assert property (s_blocked_timing_write |=> $stable(timing0))
    else $error("protected timing write took effect while locked");
  a_blocked_write_silent: assert property (regBus.wrEn && selMC && !unlocked
    |=> rewriteEnable == $past(rewriteEnable))
    else $error("mode enable changed while locked");
  a_optimal_readback: assert property ((timing0 & `FRBC_TIM_MASK) == 16'h4805
    |-> readT0 == `FRBC_TIM_OPTIMAL)
    else $error("optimal timing fields do not read 5885h");
  a_data_timing_pick: assert property (!memExpansion ##1 !memExpansion
    |-> dataAreaTiming == progAreaTiming)
    else $error("single-chip data timing differs from program timing");
  a_expansion_data_sel: assert property (memExpansion |=> dataAreaTiming == $past(readT3))
    else $error("expansion data area not using timing 3");
  a_force_separate: assert property (forceSep |=> csForcedFormat == 2'b11 && busMux == 2'b00)
    else $error("timing write did not force separate format");
  a_hold_ignored: assert property (inRewrite |=> !holdAck)
    else $error("hold acknowledged during rewrite");
  sequence s_enable_write;
    protWr && selMC && regBus.wdata[0];
  endsequence
  a_enter_rewrite: assert property (s_enable_write ##1 !abortEvt |=> ##1 rewriteMode)
    else $error("rewrite mode not entered two cycles after enable");
  a_leave_rewrite: assert property (protWr && selMC && !regBus.wdata[0] |=> ##2 !rewriteMode)
    else $error("normal mode not restored");
  a_abort_reset: assert property (abortEvt |=> !modeSelect && flashReadArray)
    else $error("abort did not reset control and enter read array");
endmodule : flash_rewrite_bus_control

//--- inc/frbc_defines.svh
/*
 * Register offsets, field positions, reset values and keys of the flash rewrite bus control.
 * Assumes a byte-addressed APB map with one aligned 32-bit word per register.
 */
`ifndef FRBC_DEFINES_SVH
`define FRBC_DEFINES_SVH
// Register byte offsets; timing 0/3 share storage with external bus control 0/3.
`define FRBC_OFS_TIMING0   8'h00
`define FRBC_OFS_TIMING3   8'h04
`define FRBC_OFS_BOUND_A   8'h08
`define FRBC_OFS_BOUND_B   8'h0C
`define FRBC_OFS_BOUND_C   8'h10
`define FRBC_OFS_FCTRL0    8'h14
`define FRBC_OFS_PROTECT   8'h18
`define FRBC_OFS_MODECTL   8'h1C
`define FRBC_OFS_BUSFMT    8'h20
// Timing register: writable field mask and bits that always read as one.
`define FRBC_TIM_MASK      16'h6F1F
`define FRBC_TIM_FIXED     16'h1080
`define FRBC_TIM_RESET     16'h0000
`define FRBC_TIM_OPTIMAL   16'h5885
// Flash control register 0 bit positions.
`define FRBC_FC_MODESEL    0
`define FRBC_FC_LOCKMODE   1
`define FRBC_FC_LOCKSTAT   2
`define FRBC_FC_RDREADY    3
`define FRBC_FC_FINALBUSY  4
// Mode control and bus format bit positions.
`define FRBC_MC_ENABLE     0
`define FRBC_BF_MUX0       0
`define FRBC_BF_MUX3       1
// Protect release key and reset values.
`define FRBC_PROTECT_KEY   8'hAA
`define FRBC_BYTE_RESET    8'h00
`endif

//--- inc/frbc_pkg.sv
/*
 * Types of the flash rewrite bus control.
 * Assumes the defines header supplies all numeric constants.
 */
package frbc_pkg;
  // Operating mode of the device as seen by the rewrite logic.
  typedef enum logic [1:0] {
    FRBC_NORMAL,
    FRBC_REWRITE,
    FRBC_REWRITE_HELD
  } frbc_mode_type;
  // One 16-bit timing / external bus control word.
  typedef logic [15:0] frbc_timing_type;
endpackage : frbc_pkg

//--- inc/frbc_reg_if.sv
/*
 * Register access channel between the APB slave and the register file.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface frbc_reg_if;
  logic        wrEn;   // One-cycle write strobe, taken with pready.
  logic [7:0]  addr;   // Byte address of the access.
  logic [31:0] wdata;  // Write data.
  logic [31:0] rdata;  // Read data of the addressed register.
  logic        hit;    // Address maps to a register.
  modport slave (output wrEn, addr, wdata, input rdata, hit);
  modport regs  (input wrEn, addr, wdata, output rdata, hit);
endinterface : frbc_reg_if

//--- rtl/frbc_apb_slave.sv
/*
 * APB slave front end: one wait state, registered answer, error on unmapped address.
 * Assumes an APB master that holds the request until pready.
 */
`timescale 1ns/1ps
module frbc_apb_slave (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  frbc_reg_if.slave        bus
);
  // Access phase seen and not yet answered.
  wire accessPending = psel & penable & ~pready;

  // The write lands at the edge where pready is sampled high.
  assign bus.wrEn  = psel & penable & pready & pwrite & bus.hit;
  assign bus.addr  = paddr;
  assign bus.wdata = pwdata;

  // Answer one cycle into the access phase; reads capture the register then.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= accessPending;
      pslverr <= accessPending & ~bus.hit;
      if (accessPending) begin
        prdata <= (!pwrite && bus.hit) ? bus.rdata : 32'h0000_0000;
      end
    end
  end

  // An access phase is answered exactly one cycle later.
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  a_apb_answer_time: assert property (@(posedge core_clk) disable iff (!rstn)
    s_access |=> pready)
    else $error("APB answer not one cycle after access phase");
endmodule : frbc_apb_slave

//--- rtl/frbc_sync.sv
/*
 * Multi-bit two-or-more stage level synchroniser for pin inputs.
 * Assumes each bit is an independent slow level.
 */
`timescale 1ns/1ps
module frbc_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  // Fewer than two stages would let a metastable value reach logic.
  initial begin
    if (STAGES < 2 || WIDTH < 1) begin
      $error("frbc_sync needs STAGES >= 2 and WIDTH >= 1");
    end
  end

  logic [WIDTH-1:0] stage [STAGES];  // Only the next stage reads each stage; dout reads the last one.

  // Each stage is a plain register chain.
  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          stage[g] <= '0;
        end else begin
          stage[g] <= (g == 0) ? din : stage[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign dout = stage[STAGES-1];
endmodule : frbc_sync

//--- sim/frbc_flash_model.sv
/*
 * Behavioural flash array status pins for the rewrite bus control.
 * Assumes a command start pulse from the bench and the core clock.
 */
`timescale 1ns/1ps
module frbc_flash_model #(
  parameter int FINAL_CYCLES = 16,
  parameter int TOTAL_CYCLES = 32
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic cmdStart,
  input  wire logic lockState,
  output logic      flashReadyPin,
  output logic      flashFinalBusyPin,
  output logic      flashLockPin
);
  int busyCount;  // Cycles left of the running command.
  // A command keeps the array busy, and refuses the last command early on.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      busyCount <= 0;
    end else if (cmdStart) begin
      busyCount <= TOTAL_CYCLES;
    end else if (busyCount > 0) begin
      busyCount <= busyCount - 1;
    end
  end
  assign flashReadyPin     = (busyCount == 0);
  assign flashFinalBusyPin = (busyCount > TOTAL_CYCLES - FINAL_CYCLES);
  assign flashLockPin      = lockState;
endmodule : frbc_flash_model

//--- sim/flash_rewrite_bus_control_test.sv
/*
 * Self-checking bench: APB register tests of the flash rewrite bus control.
 * Assumes the defines header and the flash status model.
 */
`timescale 1ns/1ps
`include "frbc_defines.svh"
module flash_rewrite_bus_control_test;
  logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, saved;
  logic        pready, pslverr, err, memExp = 0, holdReq = 1, extWait = 1;
  logic [3:0]  abortPins = 4'h0;
  logic        cmdStart = 0, flashReady, finalBusy, flashLock;
  logic [15:0] progT, dataT;
  logic        rwMode, cpuHeld, extWaitOk, holdAck, readArray, lockBus;
  logic [1:0]  csForced, csBlocked;
  int          n_fail = 0, check_count = 0, cycles = 0, k;
  // Clock at 200 MHz.
  always #2.5 core_clk = ~core_clk;
  flash_rewrite_bus_control DUT (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .memExpansionPin(memExp), .holdRequestPin(holdReq),
    .extWaitPin(extWait), .abortEventPins(abortPins), .flashReadyPin(flashReady),
    .flashFinalBusyPin(finalBusy), .flashLockPin(flashLock), .progAreaTiming(progT),
    .dataAreaTiming(dataT), .rewriteMode(rwMode), .cpuHeldRewrite(cpuHeld),
    .csForcedFormat(csForced), .csDataBlocked(csBlocked), .extWaitAccepted(extWaitOk),
    .holdAck(holdAck), .flashReadArray(readArray), .lockViaDataBus(lockBus));
  frbc_flash_model FLASH (.core_clk(core_clk), .rstn(rstn), .cmdStart(cmdStart),
    .lockState(1'b1), .flashReadyPin(flashReady), .flashFinalBusyPin(finalBusy),
    .flashLockPin(flashLock));
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // Compares one value against its expectation.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  // Register write, and register read with comparison.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("register", exp, rd);
  endtask : rdc
  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  // Main sequence of register and pin tests.
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge core_clk);
    for (k = 0; k < 3; k++) rdc(`FRBC_OFS_BOUND_A + 8'(4 * k), 32'h0);
    wr(`FRBC_OFS_BOUND_A, 32'h44);
    rdc(`FRBC_OFS_BOUND_A, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("slverr", 1, err);
    apb(1'b0, `FRBC_OFS_TIMING0, 32'h0);
    saved = rd;
    chk("saved", 32'h1080, saved);
    wr(`FRBC_OFS_PROTECT, 32'hAA);
    wr(`FRBC_OFS_TIMING0, 32'hFFFF);
    rdc(`FRBC_OFS_TIMING0, 32'h7F9F);
    wr(`FRBC_OFS_TIMING0, 32'h4805);
    rdc(`FRBC_OFS_TIMING0, 32'h5885);
    chk("progT", 32'h5885, progT);
    chk("dataT", 32'h5885, dataT);
    for (k = 0; k < 3; k++) wr(`FRBC_OFS_BOUND_A + 8'(4 * k), 32'h80 >> k);
    for (k = 0; k < 3; k++) rdc(`FRBC_OFS_BOUND_A + 8'(4 * k), 32'h80 >> k);
    chk("holdAck", 1, holdAck);
    wr(`FRBC_OFS_MODECTL, 32'h1);
    repeat (3) @(posedge core_clk);
    chk("rwMode", 1, rwMode);
    chk("holdAck", 0, holdAck);
    wr(`FRBC_OFS_FCTRL0, 32'h3);
    repeat (2) @(posedge core_clk);
    chk("cpuHeld", 1, cpuHeld);
    chk("lockBus", 0, lockBus);
    rdc(`FRBC_OFS_FCTRL0, 32'h0F);
    cmdStart <= 1'b1;
    @(posedge core_clk);
    cmdStart <= 1'b0;
    @(posedge core_clk);
    rdc(`FRBC_OFS_FCTRL0, 32'h17);
    k = 0;
    do begin
      apb(1'b0, `FRBC_OFS_FCTRL0, 32'h0);
      k++;
    end while (rd[4] !== 1'b0 && k < 20);
    chk("final", 32'h07, rd);
    repeat (40) @(posedge core_clk);
    rdc(`FRBC_OFS_FCTRL0, 32'h0F);
    wr(`FRBC_OFS_FCTRL0, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("lockBus", 1, lockBus);
    rdc(`FRBC_OFS_FCTRL0, 32'h09);
    wr(`FRBC_OFS_FCTRL0, 32'h3);
    abortPins <= 4'h1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (readArray !== 1'b1 && k < 10);
    chk("readArray", 1, readArray);
    abortPins <= 4'h0;
    repeat (4) @(posedge core_clk);
    rdc(`FRBC_OFS_FCTRL0, 32'h08);
    memExp <= 1'b1;
    repeat (8) @(posedge core_clk);
    wr(`FRBC_OFS_BUSFMT, 32'h3);
    chk("extWaitOk", 1, extWaitOk);
    wr(`FRBC_OFS_TIMING3, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("csForced", 3, csForced);
    chk("extWaitOk", 0, extWaitOk);
    chk("dataT", 32'h1081, dataT);
    chk("progT", 32'h5885, progT);
    rdc(`FRBC_OFS_BUSFMT, 32'h0);
    wr(`FRBC_OFS_BUSFMT, 32'h3);
    repeat (2) @(posedge core_clk);
    chk("csBlocked", 3, csBlocked);
    wr(`FRBC_OFS_MODECTL, 32'h0);
    repeat (3) @(posedge core_clk);
    chk("rwMode", 0, rwMode);
    wr(`FRBC_OFS_TIMING0, saved);
    rdc(`FRBC_OFS_TIMING0, 32'h1080);
    wr(`FRBC_OFS_PROTECT, 32'h0);
    wr(`FRBC_OFS_BOUND_A, 32'h11);
    rdc(`FRBC_OFS_BOUND_A, 32'h80);
    stop_test();
  end
endmodule : flash_rewrite_bus_control_test
